/* File: rtl/flash_collision_params.svh */
`ifndef FLASH_COLLISION_PARAMS_SVH
`define FLASH_COLLISION_PARAMS_SVH

// address width of the flash array, byte addressed
`define ADDR_W          16
// data width of one read beat
`define DATA_W          32
// low address bits that select a byte inside a longword
`define LONGWORD_LSB    2
// value of the command complete flag while the flash is busy
`define CCF_BUSY        1'b0
// value of the command complete flag when idle
`define CCF_IDLE        1'b1
// reset value of the fault flags
`define FAULT_RESET     1'b0
// data returned by a defective read
`define BAD_DATA        32'hDEADBEEF
// cycles a program or erase command keeps the flash busy
`define BUSY_CYCLES     16'h0020
// busy-read count at which a read collides; the 2-bit counter wraps so every fourth busy read collides
`define COLLIDE_EVERY   2'h1

`endif

/* File: rtl/flash_collision_pkg.sv */
package flash_collision_pkg;

    // device-side sequencer states
    typedef enum logic [2:0] {
        DEV_IDLE = 3'h1,
        DEV_BUSY = 3'h2,
        DEV_DONE = 3'h4
    } dev_state_e;

    // cpu-side sequencer states
    typedef enum logic [5:0] {
        CPU_IDLE  = 6'h01,
        CPU_POLL  = 6'h02,
        CPU_READ  = 6'h04,
        CPU_CLEAR = 6'h08,
        CPU_DUMMY = 6'h10,
        CPU_RETRY = 6'h20
    } cpu_state_e;

endpackage

/* File: rtl/flash_link_if.sv */
`timescale 1ns/1ps
`include "flash_collision_params.svh"

// cpu to flash controller link
interface flash_link_if;
    logic                 cmd_start;
    logic                 rd_req;
    logic [`ADDR_W-1:0]   rd_addr;
    logic                 clear_faults;
    logic                 rd_ack;
    logic [`DATA_W-1:0]   rd_data;
    logic                 command_complete_flag;
    logic                 single_fault_flag;
    logic                 double_fault_flag;

    modport dev (
        input  cmd_start,
        input  rd_req,
        input  rd_addr,
        input  clear_faults,
        output rd_ack,
        output rd_data,
        output command_complete_flag,
        output single_fault_flag,
        output double_fault_flag
    );

    modport cpu (
        output cmd_start,
        output rd_req,
        output rd_addr,
        output clear_faults,
        input  rd_ack,
        input  rd_data,
        input  command_complete_flag,
        input  single_fault_flag,
        input  double_fault_flag
    );
endinterface

/* File: rtl/flash_ctrl_dev.sv */
`timescale 1ns/1ps
`include "flash_collision_params.svh"


module flash_ctrl_dev #(
    parameter logic [15:0] BUSY_LEN = `BUSY_CYCLES
) (
    input  wire logic                core_clk,
    input  wire logic                srst,
    flash_link_if.dev                link,
    input  wire logic                arr_data_valid,
    input  wire logic [`DATA_W-1:0]  arr_data,
    output logic                     busy_out
);

    flash_collision_pkg::dev_state_e state_reg;
    logic [15:0]                     cnt_reg;
    logic [1:0]                      rdcnt_reg;
    logic                            poison_reg;
    logic [`ADDR_W-`LONGWORD_LSB-1:0] poison_lw_reg;
    logic                            ack_reg;
    logic [`DATA_W-1:0]              data_reg;
    logic                            ccf_reg;
    logic                            sf_reg;
    logic                            df_reg;
    logic                            busy_reg;
    logic                            collide;
    logic                            same_lw;

    // longword index of an address
    function automatic logic [`ADDR_W-`LONGWORD_LSB-1:0] lw_of(
        input logic [`ADDR_W-1:0] a);
        lw_of = a[`ADDR_W-1:`LONGWORD_LSB];
    endfunction

    // a read that arrives while the array is busy
    function automatic logic busy_rd(
        input logic                            req,
        input flash_collision_pkg::dev_state_e st);
        busy_rd = req && (st == flash_collision_pkg::DEV_BUSY);
    endfunction

    // a start command that the idle sequencer accepts
    function automatic logic cmd_taken(
        input logic                            start,
        input flash_collision_pkg::dev_state_e st);
        cmd_taken = start && (st == flash_collision_pkg::DEV_IDLE);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // collision decode
    // some busy reads collide
    // a fixed pattern picks the colliding reads so every run repeats exactly
    assign collide = busy_rd(link.rd_req, state_reg) && (rdcnt_reg == `COLLIDE_EVERY);
    // any byte of the remembered longword hits the stale read path
    assign same_lw = poison_reg && (lw_of(link.rd_addr) == poison_lw_reg);

    //////////////////////////////////////////////////////////////////////////
    // program/erase sequencer
    // a start while busy or done is dropped without any sign
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg <= flash_collision_pkg::DEV_IDLE;
            cnt_reg   <= 16'h0000;
        end else begin
            case (state_reg)
                flash_collision_pkg::DEV_IDLE: begin
                    if (link.cmd_start) begin
                        state_reg <= flash_collision_pkg::DEV_BUSY;
                        cnt_reg   <= BUSY_LEN;
                    end
                end
                flash_collision_pkg::DEV_BUSY: begin
                    if (cnt_reg <= 16'h0001) begin
                        state_reg <= flash_collision_pkg::DEV_DONE;
                    end
                    cnt_reg <= cnt_reg - 16'h0001;
                end
                flash_collision_pkg::DEV_DONE: begin
                    state_reg <= flash_collision_pkg::DEV_IDLE;
                end
                default: begin
                    state_reg <= flash_collision_pkg::DEV_IDLE;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // command complete flag
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ccf_reg <= `CCF_IDLE;
        end else begin
            if (cmd_taken(link.cmd_start, state_reg)) begin
                ccf_reg <= `CCF_BUSY;
            end else if (state_reg == flash_collision_pkg::DEV_DONE) begin
                ccf_reg <= `CCF_IDLE;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // busy output, high for exactly the span the complete flag is low
    always_ff @(posedge core_clk) begin
        if (srst) begin
            busy_reg <= 1'b0;
        end else begin
            if (cmd_taken(link.cmd_start, state_reg)) begin
                busy_reg <= 1'b1;
            end else if (state_reg == flash_collision_pkg::DEV_DONE) begin
                busy_reg <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // busy-read counter, picks which reads collide
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdcnt_reg <= 2'h0;
        end else if (busy_rd(link.rd_req, state_reg)) begin
            rdcnt_reg <= rdcnt_reg + 2'h1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // poisoned longword tracking
    // the longword of a colliding read stays stale in the read path
    // until any other read moves the path on
    always_ff @(posedge core_clk) begin
        if (srst) begin
            poison_reg    <= 1'b0;
            poison_lw_reg <= '0;
        end else if (collide) begin
            poison_reg    <= 1'b1;
            poison_lw_reg <= lw_of(link.rd_addr);
        end else if (link.rd_req && !same_lw) begin
            // a read elsewhere flushes the stale longword
            poison_reg <= 1'b0;
        end else if (link.rd_req && same_lw) begin
            poison_reg <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read answer, one cycle after request
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= link.rd_req;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read data, held until the next read
    always_ff @(posedge core_clk) begin
        if (srst) begin
            data_reg <= '0;
        end else if (link.rd_req) begin
            if (same_lw && !collide) begin
                data_reg <= `BAD_DATA;
            end else if (collide) begin
                data_reg <= `BAD_DATA;
            end else begin
                data_reg <= arr_data_valid ? arr_data : '0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // fault flags, set wins over clear
    // a clear landing with a new collision is dropped so no error is missed
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sf_reg <= `FAULT_RESET;
            df_reg <= `FAULT_RESET;
        end else begin
            if (collide) begin
                sf_reg <= 1'b1;
                df_reg <= 1'b1;
            end else if (link.clear_faults) begin
                sf_reg <= 1'b0;
                df_reg <= 1'b0;
            end
        end
    end

    // every link output comes straight from its flop
    assign link.rd_ack                = ack_reg;
    assign link.rd_data               = data_reg;
    assign link.command_complete_flag = ccf_reg;
    assign link.single_fault_flag     = sf_reg;
    assign link.double_fault_flag     = df_reg;
    assign busy_out                   = busy_reg;

endmodule // flash_ctrl_dev

/* File: rtl/flash_cpu_end.sv */
`timescale 1ns/1ps
`include "flash_collision_params.svh"

// cpu end: starts commands, polls, reads, recovers from collisions
module flash_cpu_end (
    input  wire logic                core_clk,
    input  wire logic                srst,
    flash_link_if.cpu                link,
    input  wire logic                user_cmd,
    input  wire logic                user_rd,
    input  wire logic [`ADDR_W-1:0]  user_addr,
    input  wire logic                user_wait_idle,
    output logic                     user_done,
    output logic [`DATA_W-1:0]       user_data,
    output logic                     user_recovered
);

    flash_collision_pkg::cpu_state_e state_reg;
    logic                 cmd_reg;
    logic                 rd_reg;
    logic                 clr_reg;
    logic [`ADDR_W-1:0]   addr_reg;
    logic [`ADDR_W-1:0]   tgt_reg;
    logic                 wait_reg;
    logic                 done_reg;
    logic [`DATA_W-1:0]   data_reg;
    logic                 rec_reg;
    logic                 faulted;

    assign faulted = link.single_fault_flag || link.double_fault_flag;

    //////////////////////////////////////////////////////////////////////////
    // cpu sequencer
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg <= flash_collision_pkg::CPU_IDLE;
            cmd_reg   <= 1'b0;
            rd_reg    <= 1'b0;
            clr_reg   <= 1'b0;
            addr_reg  <= '0;
            tgt_reg   <= '0;
            wait_reg  <= 1'b0;
            done_reg  <= 1'b0;
            data_reg  <= '0;
            rec_reg   <= 1'b0;
        end else begin
            cmd_reg  <= 1'b0;
            rd_reg   <= 1'b0;
            clr_reg  <= 1'b0;
            done_reg <= 1'b0;
            case (state_reg)
                flash_collision_pkg::CPU_IDLE: begin
                    if (user_cmd) begin
                        cmd_reg <= 1'b1;
                    end else if (user_rd) begin
                        tgt_reg   <= user_addr;
                        wait_reg  <= user_wait_idle;
                        rec_reg   <= 1'b0;
                        state_reg <= flash_collision_pkg::CPU_POLL;
                    end
                end
                flash_collision_pkg::CPU_POLL: begin
                    if (!wait_reg || link.command_complete_flag == `CCF_IDLE) begin
                        rd_reg    <= 1'b1;
                        addr_reg  <= tgt_reg;
                        state_reg <= flash_collision_pkg::CPU_READ;
                    end
                end
                flash_collision_pkg::CPU_READ: begin
                    if (link.rd_ack && !rd_reg) begin
                        if (faulted) begin
                            clr_reg   <= 1'b1;
                            rec_reg   <= 1'b1;
                            state_reg <= flash_collision_pkg::CPU_CLEAR;
                        end else begin
                            done_reg  <= 1'b1;
                            data_reg  <= link.rd_data;
                            state_reg <= flash_collision_pkg::CPU_IDLE;
                        end
                    end
                end
                flash_collision_pkg::CPU_CLEAR: begin
                    rd_reg    <= 1'b1;
                    addr_reg  <= tgt_reg ^ (`ADDR_W'(1) << `LONGWORD_LSB);
                    state_reg <= flash_collision_pkg::CPU_DUMMY;
                end
                flash_collision_pkg::CPU_DUMMY: begin
                    if (link.rd_ack && !rd_reg) begin
                        if (faulted) begin
                            clr_reg   <= 1'b1;
                            state_reg <= flash_collision_pkg::CPU_CLEAR;
                        end else begin
                            state_reg <= flash_collision_pkg::CPU_RETRY;
                        end
                    end
                end
                flash_collision_pkg::CPU_RETRY: begin
                    rd_reg    <= 1'b1;
                    addr_reg  <= tgt_reg;
                    state_reg <= flash_collision_pkg::CPU_READ;
                end
                default: begin
                    state_reg <= flash_collision_pkg::CPU_IDLE;
                end
            endcase
        end
    end

    assign link.cmd_start    = cmd_reg;
    assign link.rd_req       = rd_reg;
    assign link.rd_addr      = addr_reg;
    assign link.clear_faults = clr_reg;
    assign user_done         = done_reg;
    assign user_data         = data_reg;
    assign user_recovered    = rec_reg;

endmodule // flash_cpu_end

/* File: tb/flash_link_checker.sv */
`timescale 1ns/1ps
`include "flash_collision_params.svh"

// watches the link between the cpu end and the flash controller
module flash_link_checker #(
    parameter int BUSY_LEN = 32
) (
    input wire logic               core_clk,
    input wire logic               srst,
    input wire logic               cmd_start,
    input wire logic               rd_req,
    input wire logic [`ADDR_W-1:0] rd_addr,
    input wire logic               clear_faults,
    input wire logic               rd_ack,
    input wire logic [`DATA_W-1:0] rd_data,
    input wire logic               command_complete_flag,
    input wire logic               single_fault_flag,
    input wire logic               double_fault_flag
);
    // cycles the complete flag stays low after it falls
    localparam int LOW_N = BUSY_LEN + 1;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////////////
    // device side
    a_busy_on_start: assert property (
        cmd_start && command_complete_flag |=> !command_complete_flag)
        else $error("complete flag not low after start");
    a_busy_length: assert property (
        $fell(command_complete_flag) |-> ##LOW_N $rose(command_complete_flag))
        else $error("busy period has wrong length");
    a_ack_follows: assert property (
        rd_ack == $past(rd_req))
        else $error("read answer not one cycle after request");
    a_flags_pair: assert property (
        single_fault_flag == double_fault_flag)
        else $error("fault flags differ");
    a_collide_busy: assert property (
        $rose(single_fault_flag) |-> $past(rd_req) && !$past(command_complete_flag))
        else $error("fault raised without a busy read");
    a_bad_data: assert property (
        $rose(single_fault_flag) |-> rd_ack && rd_data == `BAD_DATA)
        else $error("colliding read returned other data");
    a_flags_sticky: assert property (
        $fell(single_fault_flag) |-> $past(clear_faults))
        else $error("fault flag dropped without a clear");

    ////////////////////////////////////////////////////////////////////////////
    // cpu side
    a_cpu_clears: assert property (
        $rose(single_fault_flag) |-> ##[1:3] clear_faults)
        else $error("cpu did not clear the fault flags");
    a_dummy_read: assert property (
        clear_faults |-> ##[1:4] rd_req)
        else $error("no read after clearing faults");
endmodule // flash_link_checker

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`include "flash_collision_params.svh"

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

module tb_top;
    localparam logic [15:0] BL = 16'h0010;
    logic               core_clk;
    logic               srst;
    logic               user_cmd;
    logic               user_rd;
    logic [`ADDR_W-1:0] user_addr;
    logic               user_wait_idle;
    logic               user_done;
    logic [`DATA_W-1:0] user_data;
    logic               user_recovered;
    logic               busy_out;
    logic               busy_b;
    int                 n_errors = 0;
    int                 n_tests = 0;
    int                 cycles = 0;

    flash_link_if link ();
    flash_link_if link_b ();

    // array contents seen at any byte address
    function automatic logic [31:0] arr_f(input logic [15:0] a);
        return {a, ~a};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // two ends facing each other, plus a device driven directly
    flash_ctrl_dev #(.BUSY_LEN(BL)) u_flash_ctrl_dev (
        .core_clk       (core_clk),
        .srst           (srst),
        .link           (link),
        .arr_data_valid (1'b1),
        .arr_data       (arr_f(link.rd_addr)),
        .busy_out       (busy_out)
    );
    flash_ctrl_dev #(.BUSY_LEN(BL)) u_flash_ctrl_dev_b (
        .core_clk       (core_clk),
        .srst           (srst),
        .link           (link_b),
        .arr_data_valid (1'b1),
        .arr_data       (arr_f(link_b.rd_addr)),
        .busy_out       (busy_b)
    );
    flash_cpu_end u_flash_cpu_end (
        .core_clk       (core_clk),
        .srst           (srst),
        .link           (link),
        .user_cmd       (user_cmd),
        .user_rd        (user_rd),
        .user_addr      (user_addr),
        .user_wait_idle (user_wait_idle),
        .user_done      (user_done),
        .user_data      (user_data),
        .user_recovered (user_recovered)
    );
    flash_link_checker #(.BUSY_LEN(int'(BL))) u_flash_link_checker (
        .core_clk              (core_clk),
        .srst                  (srst),
        .cmd_start             (link.cmd_start),
        .rd_req                (link.rd_req),
        .rd_addr               (link.rd_addr),
        .clear_faults          (link.clear_faults),
        .rd_ack                (link.rd_ack),
        .rd_data               (link.rd_data),
        .command_complete_flag (link.command_complete_flag),
        .single_fault_flag     (link.single_fault_flag),
        .double_fault_flag     (link.double_fault_flag)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cyc(input int n = 1);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    task automatic start_cmd();
        user_cmd = 1'b1;
        cyc();
        user_cmd = 1'b0;
    endtask

    task automatic user_read(input logic [15:0] a, input logic w);
        int k;
        k = 0;
        user_addr = a;
        user_wait_idle = w;
        user_rd = 1'b1;
        cyc();
        user_rd = 1'b0;
        while (user_done !== 1'b1 && k < 200) begin
            cyc();
            k++;
        end
        `CHK(user_done, 1'b1)
        `CHK(user_data, arr_f(a))
    endtask

    task automatic wait_idle(output int k);
        k = 0;
        while (link.command_complete_flag !== 1'b1 && k < 100) begin
            cyc();
            k++;
        end
        `CHK(link.command_complete_flag, `CCF_IDLE)
    endtask

    task automatic raw_rd(input logic [15:0] a, input logic [31:0] d, input logic f);
        link_b.rd_addr = a;
        link_b.rd_req = 1'b1;
        cyc();
        link_b.rd_req = 1'b0;
        `CHK(link_b.rd_ack, 1'b1)
        `CHK(link_b.rd_data, d)
        `CHK({link_b.single_fault_flag, link_b.double_fault_flag}, {f, f})
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        `CHK(link.command_complete_flag, `CCF_IDLE)
        `CHK(link.single_fault_flag, `FAULT_RESET)
        `CHK(busy_out, 1'b0)
        user_read(16'h0040, 1'b1);
        `CHK(user_recovered, 1'b0)
        $display("done: reset and idle read");
    endtask

    task automatic t_busy();
        int k;
        start_cmd();
        cyc();
        `CHK(link.command_complete_flag, `CCF_BUSY)
        `CHK(busy_out, 1'b1)
        wait_idle(k);
        `CHK(k, int'(BL) + 1)
        $display("done: busy length");
    endtask

    task automatic t_poll();
        start_cmd();
        user_read(16'h0080, 1'b1);
        `CHK(link.command_complete_flag, `CCF_IDLE)
        `CHK(user_recovered, 1'b0)
        $display("done: polled read");
    endtask

    task automatic t_collide();
        int k;
        start_cmd();
        user_read(16'h0100, 1'b0);
        user_read(16'h0104, 1'b0);
        `CHK(user_recovered, 1'b1)
        `CHK(link.double_fault_flag, 1'b0)
        wait_idle(k);
        $display("done: collision recovery");
    endtask

    task automatic t_raw();
        link_b.cmd_start = 1'b1;
        cyc();
        link_b.cmd_start = 1'b0;
        raw_rd(16'h0010, arr_f(16'h0010), 1'b0);
        `CHK(link_b.command_complete_flag, `CCF_BUSY)
        `CHK(busy_b, 1'b1)
        raw_rd(16'h0012, `BAD_DATA, 1'b1);
        cyc(2);
        `CHK(link_b.single_fault_flag, 1'b1)
        link_b.clear_faults = 1'b1;
        cyc();
        link_b.clear_faults = 1'b0;
        `CHK(link_b.double_fault_flag, 1'b0)
        raw_rd(16'h0011, `BAD_DATA, 1'b0);
        raw_rd(16'h0010, arr_f(16'h0010), 1'b0);
        $display("done: second read of longword");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        srst = 1'b1;
        user_cmd = 1'b0;
        user_rd = 1'b0;
        user_addr = '0;
        user_wait_idle = 1'b0;
        link_b.cmd_start = 1'b0;
        link_b.rd_req = 1'b0;
        link_b.rd_addr = '0;
        link_b.clear_faults = 1'b0;
        cyc(20);
        srst = 1'b0;
        cyc();
        t_reset();
        t_busy();
        t_poll();
        t_collide();
        t_raw();
        stop_test();
    end
endmodule // tb_top
